// ### design/ramp_cmd_pkg.sv
// Summary of operation
// - ramp time unsigned ms, reset zero
// - in-regulation ramp: s-curve (linear in linear mode) over full time
// - s-curve entry: decelerating half, half time
// - linear entry: full ramp time
// - reversed entry: accelerate then decelerate, full time
// - zero ramp time jumps target immediately
// - set-pressure loads fourth argument into ramp time
// - ramp-time command copies argument into ramp time
// - go position checked against retract/extend limits
// - go: rotational direction, geared signed numerator
// - set/reset outputs by 16-bit mask
// - simulated edges take input index 0-15
// - open loop drive -12000 to 12000 mV
// - limit drive -10000 to 10000 mV
// - null drive -2000 to 2000
// - reference filter constant 0 to 65535 ms
// - map output accepts groups 0-2 to 70-72
// - on-the-fly commands write selected parameter
// - teach step and start events 0-255
// - screen number limited 0 to 15
// - amplifier argument 0 disables, 1 enables
package ramp_cmd_pkg;
  localparam logic [7:0] ADDR_ARG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_RAMP = 8'h08;
  localparam logic [7:0] ADDR_PRESS = 8'h0C;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_LIMITS = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TARGET = 8'h1C;
  localparam logic [7:0] ADDR_OUTS = 8'h20;
  localparam logic [7:0] ADDR_DRIVE = 8'h24;
  localparam logic [7:0] ADDR_NULLREF = 8'h28;
  localparam logic [7:0] ADDR_MISC = 8'h2C;
  localparam logic [7:0] ADDR_FLY = 8'h30;
  localparam logic [7:0] CMD_SCREEN = 8'h24;
  localparam logic [7:0] CMD_EVENTS = 8'h45;
  localparam logic [7:0] CMD_GO_U = 8'h47;
  localparam logic [7:0] CMD_GO_L = 8'h67;
  localparam logic [7:0] CMD_LIMIT = 8'h4C;
  localparam logic [7:0] CMD_NULL = 8'h4E;
  localparam logic [7:0] CMD_OPEN = 8'h4F;
  localparam logic [7:0] CMD_REF = 8'h57;
  localparam logic [7:0] CMD_SETOUT = 8'h5B;
  localparam logic [7:0] CMD_RAMP = 8'h5C;
  localparam logic [7:0] CMD_SETPRESS = 8'h5E;
  localparam logic [7:0] CMD_RSTOUT = 8'h5D;
  localparam logic [7:0] CMD_AMP = 8'h61;
  localparam logic [7:0] CMD_TEACH = 8'h74;
  localparam logic [7:0] CMD_RISE = 8'h7B;
  localparam logic [7:0] CMD_FALL = 8'h7D;
  localparam logic [7:0] CMD_MAP = 8'h7F;
  localparam logic [7:0] CMD_FLY0 = 8'hD0;
  localparam logic [7:0] CMD_FLY_LO = 8'hD5;
  localparam logic [7:0] CMD_FLY_HI = 8'hDF;
  localparam int MODE_ROT = 0;
  localparam int MODE_GEAR = 1;
  localparam int MODE_REGULATE = 2;
  localparam int MODE_LINEAR = 3;
  localparam int ST_REJECT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_AMP = 2;
  localparam int ST_DIR = 3;
  localparam logic signed [15:0] OPEN_MAX = 16'sd12000;
  localparam logic signed [15:0] LIMIT_MAX = 16'sd10000;
  localparam logic signed [15:0] NULL_MAX = 16'sd2000;
  localparam logic [15:0] MAX_INDEX = 16'h000F;
  localparam logic [15:0] MAX_STEP = 16'h00FF;
  localparam logic [15:0] MAP_GROUP_MAX = 16'h0007;
  localparam logic [15:0] RAMP_RESET = 16'h0000;
  localparam int TICK_US = 1000;
  localparam int CLK_NS = 40;
  localparam int TICK_CYCLES = TICK_US * 1000 / CLK_NS;
endpackage

// ### design/ramp_profile.sv
`timescale 1ns/1ns
`default_nettype none
// target = start + delta * shape(t/T); s-curve shape 3x^2-2x^3, linear x.
// entry half-ramp uses the decelerating half of the s-curve over T/2.
module ramp_profile (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic start,
  input wire logic signed [15:0] from_value,
  input wire logic signed [15:0] to_value,
  input wire logic [15:0] duration,
  input wire logic linear,
  input wire logic half_decel,
  output logic signed [15:0] target,
  output logic busy
);
  typedef struct packed {
    logic signed [15:0] target;
    logic signed [15:0] base;
    logic signed [16:0] delta;
    logic [15:0] len;
    logic [15:0] t;
    logic lin;
    logic half;
    logic busy;
  } prof_t;
  prof_t r, next_r;

  function automatic logic signed [15:0] shape(input prof_t s);
    logic [31:0] x;
    logic [63:0] poly;
    logic signed [50:0] step;
    x = '0;
    poly = '0;
    step = '0;
    // x in Q16 of elapsed/len
    x = ({16'h0000, s.t} << 16) / {16'h0000, s.len};
    if (s.lin) begin
      poly = {32'h0000_0000, x};
    end else if (s.half) begin
      // decelerating half: second half of s-curve mapped onto [0,1]
      // map [0,1] onto the upper half [0.5,1] of the curve, then rescale its rise to [0,1]
      x = 32'h0000_8000 + (x >> 1);
      poly = ((64'd3 * x * x) >> 16) - ((64'd2 * x * x * x) >> 32);
      poly = (poly - 64'h0000_0000_0000_8000) << 1;
    end else begin
      poly = ((64'd3 * x * x) >> 16) - ((64'd2 * x * x * x) >> 32);
    end
    step = (51'(s.delta) * $signed({1'b0, poly[32:0]})) >>> 16;
    return 16'(51'(s.base) + step);
  endfunction

  always_comb begin
    next_r = r;
    if (start) begin
      next_r.base = r.target;
      next_r.delta = 17'(to_value) - 17'(r.target);
      next_r.lin = linear;
      next_r.half = half_decel & ~linear;
      next_r.t = '0;
      next_r.len = (half_decel & ~linear) ? (duration >> 1) : duration;
      if (next_r.len == 16'h0000) begin
        next_r.target = to_value;
        next_r.busy = 1'b0;
      end else begin
        next_r.target = from_value;
        next_r.base = from_value;
        next_r.delta = 17'(to_value) - 17'(from_value);
        next_r.busy = 1'b1;
      end
    end else if (r.busy && tick) begin
      next_r.t = r.t + 16'h0001;
      if (next_r.t >= r.len) begin
        next_r.target = 16'(r.base + r.delta);
        next_r.busy = 1'b0;
      end else begin
        next_r.target = shape(next_r);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign target = r.target;
  assign busy = r.busy;

  AST_ZERO_JUMP: assert property (@(posedge pclk) disable iff (!presetn)
    (start && duration == 16'h0000) |=> (target == $past(to_value) && !busy))
    else $error("zero ramp did not jump");
endmodule
`default_nettype wire

// ### design/pressure_cmd_top.sv
`timescale 1ns/1ns
`default_nettype none
module pressure_cmd_top #(
  parameter int TICK_DIV = ramp_cmd_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] actual_pressure,
  output logic signed [15:0] target_pressure,
  output logic [15:0] output_bits,
  output logic amp_enable
);
  import ramp_cmd_pkg::*;

  initial begin
    if (TICK_DIV < 1) $error("TICK_DIV must be at least 1");
  end

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] arg;
    logic [15:0] ramp;
    logic [15:0] press_cmd;
    logic [15:0] set_a;
    logic [15:0] set_b;
    logic [15:0] mode;
    logic signed [15:0] extend_lim;
    logic signed [15:0] retract_lim;
    logic signed [15:0] cmd_pos;
    logic signed [15:0] gear_num;
    logic dir_neg;
    logic [15:0] outs;
    logic signed [15:0] open_drive;
    logic signed [15:0] drive_limit;
    logic signed [15:0] null_drive;
    logic [15:0] ref_tc;
    logic [15:0] misc;
    logic [3:0] fly_sel;
    logic [15:0] fly_val;
    logic amp;
    logic reject;
    logic regulating;
    logic ramp_go;
    logic ramp_half;
    logic ramp_entry;
    logic [31:0] tick_cnt;
    logic tick;
    logic signed [15:0] target;
  } state_t;
  state_t r, next_r;

  logic signed [15:0] prof_target;
  logic prof_busy;

  function automatic logic in_srange(input logic [15:0] v, input logic signed [15:0] lim);
    return ($signed(v) >= -lim) && ($signed(v) <= lim);
  endfunction

  function automatic logic map_ok(input logic [15:0] v);
    logic [15:0] grp;
    logic [15:0] unit;
    grp = v / 16'd10;
    unit = v - grp * 16'd10;
    return (grp <= MAP_GROUP_MAX) && (unit <= 16'h0002);
  endfunction

  ramp_profile u_prof (
    .pclk(pclk),
    .presetn(presetn),
    .tick(r.tick),
    .start(r.ramp_go),
    .from_value(r.ramp_entry ? actual_pressure : r.target),
    .to_value($signed(r.press_cmd)),
    .duration(r.ramp),
    .linear(r.mode[MODE_LINEAR]),
    .half_decel(r.ramp_half),
    .target(prof_target),
    .busy(prof_busy)
  );

  always_comb begin
    logic [15:0] a;
    logic [7:0] cmd;
    logic ok;
    logic setup_wr;
    a = r.arg;
    cmd = 8'h00;
    ok = 1'b1;
    next_r = r;
    next_r.ramp_go = 1'b0;
    next_r.ramp_half = 1'b0;
    next_r.ramp_entry = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.target = prof_target;
    if (r.tick_cnt >= 32'(TICK_DIV - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
      next_r.tick = 1'b0;
    end
    // entry into regulation starts an entry ramp from measured pressure
    if (r.mode[MODE_REGULATE] && !r.regulating && actual_pressure >= $signed(r.set_a)) begin
      next_r.regulating = 1'b1;
      next_r.ramp_go = 1'b1;
      next_r.ramp_entry = 1'b1;
      // reversed entry runs a full s-curve, not the half
      next_r.ramp_half = ($signed(r.set_a) <= $signed(r.press_cmd));
    end else if (r.regulating && (!r.mode[MODE_REGULATE] || actual_pressure <= $signed(r.set_b))) begin
      next_r.regulating = 1'b0;
    end
    setup_wr = psel && !penable && !r.pready;
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      setup_wr = 1'b0;
    end
    if (psel && penable && !r.pready) begin
      if (pwrite) begin
        unique case (paddr)
          ADDR_ARG: next_r.arg = pwdata[15:0];
          ADDR_PRESS: begin
            next_r.press_cmd = pwdata[15:0];
            if (r.regulating) next_r.ramp_go = 1'b1;
          end
          ADDR_MODE: next_r.mode = pwdata[15:0];
          ADDR_LIMITS: begin
            next_r.retract_lim = pwdata[15:0];
            next_r.extend_lim = pwdata[31:16];
          end
          ADDR_FLY: next_r.fly_sel = pwdata[3:0];
          ADDR_CMD: begin
            cmd = pwdata[7:0];
            unique case (cmd)
              CMD_SETPRESS: begin
                next_r.press_cmd = pwdata[31:16];
                next_r.ramp = a;
                if (r.regulating) next_r.ramp_go = 1'b1;
              end
              CMD_RAMP: next_r.ramp = a;
              CMD_GO_U, CMD_GO_L: begin
                if (r.mode[MODE_ROT]) begin
                  ok = (a == 16'h0000) || (a == 16'hFFFF);
                  if (ok) next_r.dir_neg = a[0];
                end else if (r.mode[MODE_GEAR]) begin
                  next_r.gear_num = a;
                end else begin
                  ok = ($signed(a) >= r.retract_lim) && ($signed(a) <= r.extend_lim);
                  if (ok) next_r.cmd_pos = a;
                end
              end
              CMD_SETOUT: next_r.outs = r.outs | a;
              CMD_RSTOUT: next_r.outs = r.outs & ~a;
              CMD_RISE, CMD_FALL: begin
                ok = a <= MAX_INDEX;
                if (ok) next_r.misc[11:8] = a[3:0];
              end
              CMD_OPEN: begin
                ok = in_srange(a, OPEN_MAX);
                if (ok) next_r.open_drive = a;
              end
              CMD_LIMIT: begin
                ok = in_srange(a, LIMIT_MAX);
                if (ok) next_r.drive_limit = a;
              end
              CMD_NULL: begin
                ok = in_srange(a, NULL_MAX);
                if (ok) next_r.null_drive = a;
              end
              CMD_REF: next_r.ref_tc = a;
              CMD_MAP: begin
                ok = map_ok(a);
                if (ok) next_r.misc[7:0] = a[7:0];
              end
              CMD_TEACH, CMD_EVENTS: begin
                ok = a <= MAX_STEP;
                if (ok) next_r.misc[7:0] = a[7:0];
              end
              CMD_SCREEN: begin
                ok = a <= MAX_INDEX;
                if (ok) next_r.misc[15:12] = a[3:0];
              end
              CMD_AMP: begin
                ok = (a == 16'h0000) || (a == 16'h0001);
                if (ok) next_r.amp = a[0];
              end
              default: begin
                if (cmd == CMD_FLY0 || (cmd >= CMD_FLY_LO && cmd <= CMD_FLY_HI)) begin
                  next_r.fly_sel = cmd[3:0];
                  next_r.fly_val = a;
                end else begin
                  ok = 1'b0;
                end
              end
            endcase
            next_r.reject = ~ok;
          end
          default: next_r.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          ADDR_ARG: next_r.prdata = {16'h0000, r.arg};
          ADDR_CMD: next_r.prdata = 32'h0000_0000;
          ADDR_RAMP: next_r.prdata = {16'h0000, r.ramp};
          ADDR_PRESS: next_r.prdata = {16'h0000, r.press_cmd};
          ADDR_MODE: next_r.prdata = {16'h0000, r.mode};
          ADDR_LIMITS: next_r.prdata = {r.extend_lim, r.retract_lim};
          ADDR_STATUS: next_r.prdata = {28'h000_0000, r.dir_neg, r.amp, prof_busy, r.reject};
          ADDR_TARGET: next_r.prdata = {r.gear_num, r.target};
          ADDR_OUTS: next_r.prdata = {r.cmd_pos, r.outs};
          ADDR_DRIVE: next_r.prdata = {r.drive_limit, r.open_drive};
          ADDR_NULLREF: next_r.prdata = {r.ref_tc, r.null_drive};
          ADDR_MISC: next_r.prdata = {16'h0000, r.misc};
          ADDR_FLY: next_r.prdata = {12'h000, r.fly_sel, r.fly_val};
          default: begin
            next_r.prdata = 32'h0000_0000;
            next_r.pslverr = 1'b1;
          end
        endcase
      end
    end
    // set-A threshold copied straight from the argument on a set-pressure write; set-B is never written; no range on valid pressures
    if (setup_wr && pwrite && paddr == ADDR_CMD && pwdata[7:0] == CMD_SETPRESS) begin
      next_r.set_a = r.arg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ramp <= RAMP_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign target_pressure = r.target;
  assign output_bits = r.outs;
  assign amp_enable = r.amp;

  sequence cmd_write(logic [7:0] c);
    psel && penable && !pready && pwrite && paddr == ADDR_CMD && pwdata[7:0] == c;
  endsequence

  AST_RAMP_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_write(CMD_RAMP) |=> (r.ramp == $past(r.arg)))
    else $error("ramp command did not load ramp time");
  AST_SETPRESS_RAMP: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_write(CMD_SETPRESS) |=> (r.ramp == $past(r.arg)))
    else $error("set pressure did not load ramp time");
  AST_OUT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_write(CMD_SETOUT) |=> ((output_bits & $past(r.arg)) == $past(r.arg)))
    else $error("set outputs mask not applied");
  AST_OUT_RST: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_write(CMD_RSTOUT) |=> ((output_bits & $past(r.arg)) == 16'h0000))
    else $error("reset outputs mask not applied");
  AST_AMP: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write(CMD_AMP) and r.arg == 16'h0001) |=> amp_enable)
    else $error("amplifier not enabled");
  AST_OPEN_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write(CMD_OPEN) and !in_srange(r.arg, OPEN_MAX)) |=> (r.reject && $stable(r.open_drive)))
    else $error("out-of-range open loop accepted");
  AST_NULL_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write(CMD_NULL) and !in_srange(r.arg, NULL_MAX)) |=> $stable(r.null_drive))
    else $error("out-of-range null drive accepted");
  AST_GO_LIMITS: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write(CMD_GO_U) and (r.mode[1:0] == 2'b00 && $signed(r.arg) > r.extend_lim)) |=> $stable(r.cmd_pos))
    else $error("go beyond extend limit accepted");
  AST_SCREEN: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write(CMD_SCREEN) and r.arg > MAX_INDEX) |=> r.reject)
    else $error("bad screen number accepted");
  AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
endmodule
`default_nettype wire

// ### dv/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // latency is never assumed; the bound only stops a hung slave from stalling the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 32);
    r = prdata;
    err = (pready !== 1'b1) | (pslverr !== 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines must not keep looking valid
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### dv/pressure_ramp_command_value_test.sv
`timescale 1ns/1ns
`default_nettype none
module pressure_ramp_command_value_test;
  import ramp_cmd_pkg::*;
  localparam int TDIV = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, amp_enable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic signed [15:0] actual_pressure = 16'sd0;
  logic signed [15:0] target_pressure;
  logic [15:0] output_bits, v, m, exp_bits;
  logic e;
  int errors = 0;
  int n_tests = 0;
  int seed = 95;
  int cycles = 0;
  logic [7:0] t_code [25] = '{CMD_OPEN, CMD_OPEN, CMD_OPEN, CMD_LIMIT, CMD_LIMIT, CMD_LIMIT, CMD_NULL,
    CMD_NULL, CMD_NULL, CMD_SCREEN, CMD_SCREEN, CMD_RISE, CMD_RISE, CMD_FALL, CMD_FALL, CMD_TEACH,
    CMD_TEACH, CMD_EVENTS, CMD_EVENTS, CMD_MAP, CMD_MAP, CMD_MAP, CMD_MAP, CMD_AMP, CMD_REF};
  logic [15:0] t_arg [25] = '{16'h2EE0, 16'hD120, 16'h2EE1, 16'h2710, 16'hD8F0, 16'hD8EF, 16'h07D0,
    16'h07D1, 16'hF830, 16'h000F, 16'h0010, 16'h000F, 16'h0010, 16'h0000, 16'h0010, 16'h00FF,
    16'h0100, 16'h00FF, 16'h0100, 16'h0048, 16'h000A, 16'h000D, 16'h0049, 16'h0002, 16'hFFFF};
  logic t_rej [25] = '{0, 0, 1, 0, 0, 1, 0, 1, 0, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 0, 1, 1, 1, 0};

  always #20 pclk = ~pclk;

  host_model host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  pressure_cmd_top #(.TICK_DIV(TDIV)) pressure_cmd_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .actual_pressure(actual_pressure),
    .target_pressure(target_pressure), .output_bits(output_bits), .amp_enable(amp_enable));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_inst.xfer(1'b1, a, d, r, e);
    check("write response", {31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a);
    host_model_inst.xfer(1'b0, a, 32'h0000_0000, r, e);
    check("read response", {31'h0, e}, 32'h0);
  endtask

  task automatic cmd(input logic [7:0] code, input logic [15:0] arg, input logic [15:0] press);
    wr(ADDR_ARG, {16'h0000, arg});
    wr(ADDR_CMD, {press, 8'h00, code});
  endtask

  task automatic cmd_rej(input logic [7:0] code, input logic [15:0] arg, input logic rej);
    cmd(code, arg, 16'h0000);
    rd(ADDR_STATUS);
    check("reject flag", {31'h0, r[ST_REJECT]}, {31'h0, rej});
  endtask

  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask

  // duration measured from the end of the command write; slack covers the bus latency and the phase of the free-running tick
  task automatic ramp_chk(input logic [15:0] arg, input logic [15:0] press, input int ms);
    int n;
    n = 0;
    cmd(CMD_SETPRESS, arg, press);
    while (target_pressure !== press && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    check("ramp cycles", {31'h0, n >= ms * TDIV - 6 && n <= ms * TDIV + 6}, 32'h1);
  endtask

  // leave regulation, load the command while idle, then enter and time the entry ramp
  task automatic entry_chk(input logic [31:0] mode, input logic [15:0] arg, input logic [15:0] press,
                           input int ms);
    int n;
    n = 0;
    wr(ADDR_MODE, 32'h0000_0000);
    cmd(CMD_SETPRESS, arg, press);
    wr(ADDR_MODE, mode);
    while (target_pressure !== press && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    check("entry ramp cycles", {31'h0, n >= ms * TDIV - 6 && n <= ms * TDIV + 6}, 32'h1);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("target at reset", {16'h0, target_pressure}, 32'h0);
    check("outputs at reset", {16'h0, output_bits}, 32'h0);
    rd(ADDR_RAMP);
    check("ramp time at reset", r, 32'h0000_0000);
    host_model_inst.xfer(1'b0, 8'h40, 32'h0000_0000, r, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    $display("test reset and bus done");

    cmd(CMD_RAMP, 16'hFFFF, 16'h0000);
    rd(ADDR_RAMP);
    check("ramp time command", r, 32'h0000_FFFF);
    cmd(CMD_SETPRESS, 16'h0007, 16'h0000);
    rd(ADDR_RAMP);
    check("set pressure ramp", r, 32'h0000_0007);
    actual_pressure <= 16'sd5000;
    wr(ADDR_MODE, 32'h0000_0000);
    wr(ADDR_MODE, 32'h1 << MODE_REGULATE);
    ramp_chk(16'h0000, 16'd1000, 0);
    ramp_chk(16'd10, 16'd3000, 10);
    entry_chk((32'h1 << MODE_REGULATE) | (32'h1 << MODE_LINEAR), 16'd10, 16'd4000, 10);
    entry_chk(32'h1 << MODE_REGULATE, 16'd10, 16'd2000, 5);
    entry_chk(32'h1 << MODE_REGULATE, 16'd40, 16'd5, 40);
    $display("test ramps done");

    for (int i = 0; i < 25; i++) begin
      cmd_rej(t_code[i], t_arg[i], t_rej[i]);
    end
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed) % 12001);
      cmd_rej(CMD_OPEN, v, 1'b0);
      cmd_rej(CMD_OPEN, 16'h8000, 1'b1);
      rd(ADDR_DRIVE);
      check("open loop kept", {16'h0, r[15:0]}, {16'h0, v});
    end
    $display("test argument ranges done");

    exp_bits = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      m = 16'($random(seed));
      cmd((i % 2 == 0) ? CMD_SETOUT : CMD_RSTOUT, m, 16'h0000);
      exp_bits = (i % 2 == 0) ? (exp_bits | m) : (exp_bits & ~m);
      settle();
      check("output bits", {16'h0, output_bits}, {16'h0, exp_bits});
    end
    cmd_rej(CMD_AMP, 16'h0001, 1'b0);
    cmd_rej(CMD_AMP, 16'h0002, 1'b1);
    settle();
    check("amp kept on", {31'h0, amp_enable}, 32'h1);
    cmd_rej(CMD_AMP, 16'h0000, 1'b0);
    settle();
    check("amp off", {31'h0, amp_enable}, 32'h0);
    $display("test outputs and amplifier done");

    wr(ADDR_MODE, 32'h0000_0000);
    wr(ADDR_LIMITS, {16'h03E8, 16'hFC18});
    cmd_rej(CMD_GO_U, 16'h01F4, 1'b0);
    cmd_rej(CMD_GO_L, 16'h03E9, 1'b1);
    rd(ADDR_OUTS);
    check("go position", {16'h0, r[31:16]}, 32'h0000_01F4);
    wr(ADDR_MODE, 32'h1 << MODE_GEAR);
    cmd_rej(CMD_GO_U, 16'h8000, 1'b0);
    rd(ADDR_TARGET);
    check("gear numerator", {16'h0, r[31:16]}, 32'h0000_8000);
    wr(ADDR_MODE, 32'h1 << MODE_ROT);
    cmd_rej(CMD_GO_L, 16'hFFFF, 1'b0);
    cmd_rej(CMD_GO_U, 16'h0000, 1'b0);
    cmd_rej(CMD_GO_U, 16'h0001, 1'b1);
    for (int c = 32'hD4; c <= 32'hDF; c++) begin
      v = 16'($random(seed));
      cmd((c == 32'hD4) ? CMD_FLY0 : 8'(c), v, 16'h0000);
      rd(ADDR_FLY);
      check("on the fly value", {16'h0, r[15:0]}, {16'h0, v});
    end
    $display("test go and on the fly done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
